/* File: core/dmb_core.sv */
// Purpose: core special registers, indirect access, bank select, status flags
// Assumes: core drives one access per cycle, ALU flags computed outside
// Notes:   general storage is 128 bytes per bank inside this module
`timescale 1ns/100ps
`include "dmb_defines.svh"
module dmb_core #(
    parameter int GP_DEPTH = 128
) (
    input  wire logic                 CLK_IN,
    input  wire logic                 RST_IN,
    input  wire dmb_pkg::dmb_rst_e    RST_CAUSE_IN,
    input  wire logic [7:0]           ADDR_IN,
    input  wire logic                 RD_IN,
    input  wire logic                 WR_IN,
    input  wire logic [7:0]           WDATA_IN,
    input  wire logic                 WORK_WR_IN,
    input  wire logic [7:0]           WORK_DATA_IN,
    input  wire logic                 FLAG_UPD_IN,
    input  wire logic [3:0]           FLAG_MASK_IN,
    input  wire logic [3:0]           FLAG_VAL_IN,
    input  wire logic                 WDT_TIMEOUT_IN,
    input  wire logic                 KICK_IN,
    input  wire logic                 HALT_IN,
    input  wire logic                 TAB_RD_IN,
    input  wire logic [15:0]          PROG_WORD_IN,
    output logic [7:0]                RDATA_OUT,
    output logic [7:0]                WORKING_OUT,
    output logic [15:0]               TAB_ADDR_OUT,
    output logic [7:0]                TAB_LOW_OUT,
    output logic                      PC_JUMP_OUT,
    output logic [7:0]                PC_LOW_OUT,
    output logic                      DUMMY_CYCLE_OUT,
    output logic [7:0]                STATUS_OUT,
    output logic                      BANK_OUT
);
    logic [7:0] mem [0:2*GP_DEPTH-1];
    logic [7:0] pointer_a;
    logic [7:0] pointer_b;
    logic       bank_select_bit;
    logic [7:0] working_reg;
    logic [7:0] pc_low_byte;
    logic [7:0] tab_low;
    logic [7:0] tab_high;
    logic [7:0] table_high_latch;
    logic [3:0] arith;
    logic       wdt_expired_bit;
    logic       sleep_entered_bit;
    logic       rst_seen;

    // indirect ports resolve to a target address
    wire        sel_a     = (ADDR_IN == `DMB_ADDR_PORT_A);
    wire        sel_b     = (ADDR_IN == `DMB_ADDR_PORT_B);
    wire [7:0]  ptr       = sel_a ? pointer_a : pointer_b;
    wire        eff_bank  = sel_b ? bank_select_bit : 1'b0;
    wire [7:0]  eff_addr  = (sel_a || sel_b) ? ptr : ADDR_IN;
    // an indirect target that is itself a port reads zero and ignores writes
    wire        tgt_port  = (eff_addr == `DMB_ADDR_PORT_A) ||
                            (eff_addr == `DMB_ADDR_PORT_B);
    wire        tgt_gp    = eff_addr[7];
    wire [8:0]  full_addr = {eff_bank, eff_addr};
    // only the general half of each bank is stored, so bit 7 drops out
    wire [7:0]  gp_slot   = {full_addr[8], full_addr[6:0]};
    wire [7:0]  gp_word   = mem[gp_slot];
    wire        bank1_sfr = eff_bank && !tgt_gp;
    wire        do_wr     = WR_IN && !tgt_port && !bank1_sfr;
    wire        wr_sfr    = do_wr && !tgt_gp;
    wire [7:0]  status_rd = {2'b00, wdt_expired_bit, sleep_entered_bit, arith};

    // bank one has no special registers of its own, so that half reads zero
    logic [7:0] sfr_rd;
    always_comb begin
        sfr_rd = `DMB_ZERO_BYTE;
        if (!bank1_sfr) begin
            case (eff_addr)
                `DMB_ADDR_PTR_A:     sfr_rd = pointer_a;
                `DMB_ADDR_PTR_B:     sfr_rd = pointer_b;
                `DMB_ADDR_BANK:      sfr_rd = {7'h00, bank_select_bit};
                `DMB_ADDR_WORKING:   sfr_rd = working_reg;
                `DMB_ADDR_PC_LOW:    sfr_rd = pc_low_byte;
                `DMB_ADDR_TAB_LOW:   sfr_rd = tab_low;
                `DMB_ADDR_TAB_HIGH:  sfr_rd = tab_high;
                `DMB_ADDR_TAB_LATCH: sfr_rd = table_high_latch;
                `DMB_ADDR_STATUS:    sfr_rd = status_rd;
                default:             sfr_rd = `DMB_ZERO_BYTE;
            endcase
        end
    end
    wire [7:0] next_rdata = tgt_gp ? gp_word : sfr_rd;

    // general storage, no reset so synthesis can map it to RAM
    always_ff @(posedge CLK_IN) begin
        if (do_wr && tgt_gp) begin
            mem[gp_slot] <= WDATA_IN;
        end
    end

    // unasked reads return zero so a stale byte never looks valid
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= `DMB_RST_BYTE;
        end else begin
            RDATA_OUT <= RD_IN ? next_rdata : `DMB_ZERO_BYTE;
        end
    end

    // pointers are plain storage; software steps them like any register
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pointer_a <= `DMB_RST_BYTE;
            pointer_b <= `DMB_RST_BYTE;
        end else begin
            if (wr_sfr && eff_addr == `DMB_ADDR_PTR_A) pointer_a <= WDATA_IN;
            if (wr_sfr && eff_addr == `DMB_ADDR_PTR_B) pointer_b <= WDATA_IN;
        end
    end

    // the reset cause is sampled on the first clock after release, since an
    // asynchronous reset may only load constants
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rst_seen <= 1'b1;
        end else begin
            rst_seen <= 1'b0;
        end
    end

    logic next_bank;
    always_comb begin
        next_bank = bank_select_bit;
        if (rst_seen && RST_CAUSE_IN != dmb_pkg::DMB_RST_WDT_SLEEP) begin
            next_bank = 1'b0;
        end else if (wr_sfr && eff_addr == `DMB_ADDR_BANK) begin
            next_bank = WDATA_IN[0];
        end
    end
    // the bank bit is held through reset so a sleep watchdog wake keeps it
    always_ff @(posedge CLK_IN) begin
        bank_select_bit <= next_bank;
    end

    // all transfers between registers pass through the working register
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            working_reg <= `DMB_RST_BYTE;
        end else if (WORK_WR_IN) begin
            working_reg <= WORK_DATA_IN;
        end else if (wr_sfr && eff_addr == `DMB_ADDR_WORKING) begin
            working_reg <= WDATA_IN;
        end
    end

    // the jump stays inside the current page; the core spends the dummy cycle
    wire pc_wr = wr_sfr && (eff_addr == `DMB_ADDR_PC_LOW);
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pc_low_byte     <= `DMB_RST_BYTE;
            PC_JUMP_OUT     <= 1'b0;
            DUMMY_CYCLE_OUT <= 1'b0;
        end else begin
            if (pc_wr) pc_low_byte <= WDATA_IN;
            PC_JUMP_OUT     <= pc_wr;
            DUMMY_CYCLE_OUT <= PC_JUMP_OUT;
        end
    end

    // the latch keeps the high byte until the next table read
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tab_low          <= `DMB_RST_BYTE;
            tab_high         <= `DMB_RST_BYTE;
            table_high_latch <= `DMB_RST_BYTE;
            TAB_LOW_OUT      <= `DMB_RST_BYTE;
        end else begin
            if (wr_sfr && eff_addr == `DMB_ADDR_TAB_LOW)  tab_low  <= WDATA_IN;
            if (wr_sfr && eff_addr == `DMB_ADDR_TAB_HIGH) tab_high <= WDATA_IN;
            if (TAB_RD_IN) begin
                table_high_latch <= PROG_WORD_IN[15:8];
                TAB_LOW_OUT      <= PROG_WORD_IN[7:0];
            end
        end
    end

    // arithmetic flags: ALU update has priority over a software write
    logic [3:0] next_arith;
    always_comb begin
        next_arith = arith;
        if (wr_sfr && eff_addr == `DMB_ADDR_STATUS) next_arith = WDATA_IN[3:0];
        if (FLAG_UPD_IN) begin
            next_arith = (arith & ~FLAG_MASK_IN) | (FLAG_VAL_IN & FLAG_MASK_IN);
        end
    end
    always_ff @(posedge CLK_IN) begin
        arith <= next_arith;
    end

    // the system flags survive every reset but power-up, so a watchdog wake
    // from sleep can still be told apart from a cold start
    wire power_clear = rst_seen && (RST_CAUSE_IN == dmb_pkg::DMB_RST_POWER);
    logic next_wdt;
    logic next_sleep;
    always_comb begin
        next_wdt   = wdt_expired_bit;
        next_sleep = sleep_entered_bit;
        // a time-out or halt wins over a clear in the same cycle
        if (WDT_TIMEOUT_IN) begin
            next_wdt = 1'b1;
        end else if (power_clear || KICK_IN || HALT_IN) begin
            next_wdt = 1'b0;
        end
        if (HALT_IN) begin
            next_sleep = 1'b1;
        end else if (power_clear || KICK_IN) begin
            next_sleep = 1'b0;
        end
    end
    always_ff @(posedge CLK_IN) begin
        wdt_expired_bit   <= next_wdt;
        sleep_entered_bit <= next_sleep;
    end

    // outputs follow the registers directly, no extra stage
    always_comb begin
        WORKING_OUT  = working_reg;
        TAB_ADDR_OUT = {tab_high, tab_low};
        PC_LOW_OUT   = pc_low_byte;
        STATUS_OUT   = status_rd;
        BANK_OUT     = bank_select_bit;
    end

    a_port_read_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (RD_IN && tgt_port) |=> RDATA_OUT == 8'h00)
        else $error("indirect port target did not read zero");
    a_status_top_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        STATUS_OUT[7:6] == 2'b00)
        else $error("status upper bits not zero");
    a_bank_reads_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (RD_IN && !bank1_sfr && eff_addr == `DMB_ADDR_BANK) |=>
        RDATA_OUT == {7'h00, $past(bank_select_bit)})
        else $error("bank select readback wrong");
    a_wdt_set: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        WDT_TIMEOUT_IN |=> STATUS_OUT[`DMB_BIT_WDT])
        else $error("watchdog flag not set");
    a_kick_clears: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (KICK_IN && !HALT_IN && !WDT_TIMEOUT_IN) |=> STATUS_OUT[5:4] == 2'b00)
        else $error("kick did not clear flags");
    a_halt_sets: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (HALT_IN && !WDT_TIMEOUT_IN) |=> STATUS_OUT[5:4] == 2'b01)
        else $error("halt flags wrong");
    a_status_wr_keeps: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (wr_sfr && eff_addr == `DMB_ADDR_STATUS && !WDT_TIMEOUT_IN && !KICK_IN && !HALT_IN)
        |=> $stable(STATUS_OUT[5:4]))
        else $error("status write changed system flags");
    sequence s_pc_write;
        pc_wr;
    endsequence
    sequence s_jump_then_dummy;
        PC_JUMP_OUT ##1 DUMMY_CYCLE_OUT;
    endsequence
    a_pc_jump_dummy: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        s_pc_write |=> s_jump_then_dummy)
        else $error("pc write jump or dummy missing");
    a_table_latch: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        TAB_RD_IN |=> (TAB_LOW_OUT == $past(PROG_WORD_IN[7:0]) &&
                       table_high_latch == $past(PROG_WORD_IN[15:8])))
        else $error("table read bytes wrong");
    a_bank_reset: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (rst_seen && RST_CAUSE_IN != dmb_pkg::DMB_RST_WDT_SLEEP) |=> !BANK_OUT)
        else $error("bank not cleared by reset");

    // access path: read data stands one cycle and is zero when not asked for
    a_rdata_idle: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        !RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data not zero while idle");

    a_refused_read: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (RD_IN && bank1_sfr) |=> RDATA_OUT == 8'h00)
        else $error("bank one special area did not read zero");

    // refused writes must leave both pointers and the bank bit untouched
    a_port_write_none: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (WR_IN && tgt_port && !rst_seen) |=>
        ($stable(pointer_a) && $stable(pointer_b) && $stable(BANK_OUT)))
        else $error("write to indirect port location took effect");
    a_refused_write: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (WR_IN && bank1_sfr && !rst_seen) |=>
        ($stable(pointer_a) && $stable(pointer_b) && $stable(BANK_OUT)))
        else $error("write to bank one special area took effect");

    // pointers behave as plain storage
    sequence s_ptr_a_write;
        wr_sfr && (eff_addr == `DMB_ADDR_PTR_A);
    endsequence
    sequence s_ptr_b_write;
        wr_sfr && (eff_addr == `DMB_ADDR_PTR_B);
    endsequence
    a_ptr_a_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        s_ptr_a_write |=> pointer_a == $past(WDATA_IN))
        else $error("pointer a did not take write data");
    a_ptr_b_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        s_ptr_b_write |=> pointer_b == $past(WDATA_IN))
        else $error("pointer b did not take write data");

    a_bank_write: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (wr_sfr && eff_addr == `DMB_ADDR_BANK && !rst_seen) |=>
        BANK_OUT == $past(WDATA_IN[0]))
        else $error("bank select did not take bit zero");
    // a watchdog wake from sleep keeps the bank, any other reset clears it
    a_bank_kept_sleep: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (rst_seen && RST_CAUSE_IN == dmb_pkg::DMB_RST_WDT_SLEEP && !wr_sfr) |=>
        $stable(BANK_OUT))
        else $error("bank changed across sleep watchdog reset");

    // system flags across resets
    a_power_clears: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (power_clear && !WDT_TIMEOUT_IN && !HALT_IN) |=> STATUS_OUT[5:4] == 2'b00)
        else $error("power-up did not clear system flags");
    a_flags_kept_reset: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (rst_seen && !power_clear && !WDT_TIMEOUT_IN && !KICK_IN && !HALT_IN) |=>
        $stable(STATUS_OUT[5:4]))
        else $error("system flags changed across a warm reset");

    // arithmetic flags from software and from the ALU
    a_status_arith_wr: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (wr_sfr && eff_addr == `DMB_ADDR_STATUS && !FLAG_UPD_IN) |=>
        STATUS_OUT[3:0] == $past(WDATA_IN[3:0]))
        else $error("status write did not load arithmetic flags");
    a_flag_update: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        FLAG_UPD_IN |=> STATUS_OUT[3:0] ==
        (($past(STATUS_OUT[3:0]) & ~$past(FLAG_MASK_IN)) |
         ($past(FLAG_VAL_IN) & $past(FLAG_MASK_IN))))
        else $error("masked flag update wrong");

    a_working_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        WORK_WR_IN |=> WORKING_OUT == $past(WORK_DATA_IN))
        else $error("working register did not load");
    a_pc_low_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        pc_wr |=> PC_LOW_OUT == $past(WDATA_IN))
        else $error("pc low byte did not load");

    // table pointer bytes land in their own halves of the table address
    a_tab_low_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (wr_sfr && eff_addr == `DMB_ADDR_TAB_LOW) |=> TAB_ADDR_OUT[7:0] == $past(WDATA_IN))
        else $error("table low pointer did not load");
    a_tab_high_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (wr_sfr && eff_addr == `DMB_ADDR_TAB_HIGH) |=> TAB_ADDR_OUT[15:8] == $past(WDATA_IN))
        else $error("table high pointer did not load");
endmodule

/* File: include/dmb_defines.svh */
// Purpose: constants for the data memory banking and status flag block
// Assumes: 8-bit data memory addresses, two banks
// Notes:   offsets of the special registers are chosen locally
// Functional notes
// - indirect port access goes to pointer's address
// - pointer a bank 0 only; b any bank
// - direct access to indirect port: 00H, no write; the code sends it to the pointer's target instead
// - pointers are ordinary readable writable registers
// - bank select only bit 0; rest zero
// - reset clears bank, except sleep watchdog reset
// - direct addressing always reaches bank 0
// - pc low write jumps in page, dummy cycle
// - table read: high byte to latch, low out
// - status writes keep watchdog and sleep flags
// - watchdog flag: set timeout, clear kick/halt/power-up
// - sleep flag: set halt, clear kick/power-up
// - carry from add, no borrow, rotate
// - nibble carry from low nibble
// - zero flag set on zero result
// - signed flag: carry in differs carry out
// - status never saved on call or interrupt
// - status bits 7,6 zero; 5,4 zero at power-up
// - no direct register to register transfer
// - 00H-7FH special, 80H-FFH general storage
// - unused special locations read 00H
`ifndef DMB_DEFINES_SVH
`define DMB_DEFINES_SVH
`define DMB_ADDR_PORT_A   8'h00
`define DMB_ADDR_PTR_A    8'h01
`define DMB_ADDR_PORT_B   8'h02
`define DMB_ADDR_PTR_B    8'h03
`define DMB_ADDR_BANK     8'h04
`define DMB_ADDR_WORKING  8'h05
`define DMB_ADDR_PC_LOW   8'h06
`define DMB_ADDR_TAB_LOW  8'h07
`define DMB_ADDR_TAB_HIGH 8'h08
`define DMB_ADDR_TAB_LATCH 8'h09
`define DMB_ADDR_STATUS   8'h0A
`define DMB_GP_BASE       8'h80
`define DMB_BIT_C         0
`define DMB_BIT_NIBBLE    1
`define DMB_BIT_Z         2
`define DMB_BIT_SIGNED    3
`define DMB_BIT_SLEEP     4
`define DMB_BIT_WDT       5
`define DMB_RST_BYTE      8'h00
`define DMB_ZERO_BYTE     8'h00
`endif

/* File: include/dmb_pkg.sv */
// Purpose: shared types for the data memory banking block
// Assumes: nothing beyond the defines header
// Notes:   reset cause selects what the bank bit does
package dmb_pkg;
    typedef logic [7:0] dmb_byte_t;
    typedef enum logic [1:0] {
        DMB_RST_NONE,
        DMB_RST_POWER,
        DMB_RST_OTHER,
        DMB_RST_WDT_SLEEP
    } dmb_rst_e;
endpackage

/* File: verification/dmb_core_tb.sv */
// Purpose: self-checking bench for banking, indirect access and status flags
// Assumes: read data is settled at the falling edge after the taking edge
// Notes:   all inputs but clock, reset and reset cause come from the core model, no input is tied
`timescale 1ns/100ps
module dmb_core_tb;
    logic              clk;
    logic              rst;
    dmb_pkg::dmb_rst_e cause;
    logic [7:0]        addr, rdata, working, tab_low, pc_low, status;
    logic              rd, wr, pc_jump, dummy, bank;
    logic [15:0]       data, tab_addr;
    logic [5:0]        strobe;
    int                mismatches, comparisons, cycles;

    dmb_core dmb_core_i (.CLK_IN(clk), .RST_IN(rst), .RST_CAUSE_IN(cause), .ADDR_IN(addr),
        .RD_IN(rd), .WR_IN(wr), .WDATA_IN(data[7:0]), .WORK_WR_IN(strobe[0]),
        .WORK_DATA_IN(data[7:0]), .FLAG_UPD_IN(strobe[1]), .FLAG_MASK_IN(data[7:4]),
        .FLAG_VAL_IN(data[3:0]), .WDT_TIMEOUT_IN(strobe[2]), .KICK_IN(strobe[3]),
        .HALT_IN(strobe[4]), .TAB_RD_IN(strobe[5]), .PROG_WORD_IN(data),
        .RDATA_OUT(rdata), .WORKING_OUT(working), .TAB_ADDR_OUT(tab_addr),
        .TAB_LOW_OUT(tab_low), .PC_JUMP_OUT(pc_jump), .PC_LOW_OUT(pc_low),
        .DUMMY_CYCLE_OUT(dummy), .STATUS_OUT(status), .BANK_OUT(bank));
    dmb_cpu_model dmb_cpu_model_i (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
        .rd_out(rd), .wr_out(wr), .data_out(data), .strobe_out(strobe));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        dmb_cpu_model_i.rd(a, d);
        chk($sformatf("read %h", a), 16'(e), 16'(d));
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        dmb_cpu_model_i.wr(a, d);
    endtask
    task automatic pls(input int s, input logic [15:0] d);
        dmb_cpu_model_i.pulse(s, d);
    endtask
    // cause is held over the first edge after release, where it is sampled
    task automatic do_rst(input dmb_pkg::dmb_rst_e c);
        @(negedge clk);
        cause = c;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        cause = dmb_pkg::DMB_RST_NONE;
    endtask

    initial begin
        rst = 1'b1;
        cause = dmb_pkg::DMB_RST_POWER;
        mismatches = 0;
        comparisons = 0;
        cycles = 0;
        do_rst(dmb_pkg::DMB_RST_POWER);
        chk("status top", 16'h0000, 16'(status[7:4]));
        rchk(8'h04, 8'h00);
        put(8'h04, 8'hFF);
        rchk(8'h04, 8'h01);
        chk("bank", 16'h0001, 16'(bank));
        put(8'h04, 8'h00);
        put(8'h01, 8'h85);
        rchk(8'h01, 8'h85);
        put(8'h03, 8'h85);
        rchk(8'h03, 8'h85);
        put(8'h85, 8'h11);
        put(8'h00, 8'h22);
        rchk(8'h85, 8'h22);
        put(8'h04, 8'h01);
        put(8'h02, 8'h33);
        rchk(8'h85, 8'h22);
        rchk(8'h00, 8'h22);
        rchk(8'h02, 8'h33);
        put(8'h04, 8'h00);
        rchk(8'h02, 8'h22);
        put(8'h04, 8'h01);
        put(8'h03, 8'h04);
        rchk(8'h02, 8'h00);
        put(8'h02, 8'h00);
        chk("bank refused", 16'h0001, 16'(bank));
        put(8'h04, 8'h00);
        put(8'h01, 8'h00);
        put(8'h00, 8'h5A);
        rchk(8'h00, 8'h00);
        rchk(8'h01, 8'h00);
        rchk(8'h7F, 8'h00);
        put(8'hFF, 8'hC3);
        rchk(8'hFF, 8'hC3);
        put(8'h06, 8'h5A);
        chk("jump", 16'h0001, 16'(pc_jump));
        chk("pc low", 16'h005A, 16'(pc_low));
        @(negedge clk);
        chk("dummy", 16'h0001, 16'(dummy));
        put(8'h07, 8'h34);
        put(8'h08, 8'h12);
        chk("table addr", 16'h1234, tab_addr);
        pls(5, 16'hABCD);
        chk("table low", 16'h00CD, 16'(tab_low));
        rchk(8'h09, 8'hAB);
        pls(0, 16'h0077);
        chk("working", 16'h0077, 16'(working));
        rchk(8'h05, 8'h77);
        pls(1, 16'h00F5);
        rchk(8'h0A, 8'h05);
        pls(1, 16'h002A);
        rchk(8'h0A, 8'h07);
        put(8'h0A, 8'hFF);
        rchk(8'h0A, 8'h0F);
        pls(4, 16'h0000);
        rchk(8'h0A, 8'h1F);
        pls(2, 16'h0000);
        rchk(8'h0A, 8'h3F);
        put(8'h0A, 8'h00);
        rchk(8'h0A, 8'h30);
        pls(3, 16'h0000);
        rchk(8'h0A, 8'h00);
        pls(2, 16'h0000);
        pls(4, 16'h0000);
        rchk(8'h0A, 8'h10);
        pls(2, 16'h0000);
        put(8'h04, 8'h01);
        do_rst(dmb_pkg::DMB_RST_WDT_SLEEP);
        chk("bank kept", 16'h0001, 16'(bank));
        chk("flags kept", 16'h0003, 16'(status[5:4]));
        do_rst(dmb_pkg::DMB_RST_OTHER);
        chk("bank cleared", 16'h0000, 16'(bank));
        chk("flags warm", 16'h0003, 16'(status[5:4]));
        do_rst(dmb_pkg::DMB_RST_POWER);
        chk("status power", 16'h0000, 16'(status[7:4]));
        complete_run();
    end
endmodule

/* File: verification/dmb_cpu_model.sv */
// Purpose: behavioural core that launches accesses and instruction strobes
// Assumes: requests start and end on falling clock edges
// Notes:   strobe bits are work_wr, flag_upd, wdt, kick, halt, tab_rd
`timescale 1ns/100ps
module dmb_cpu_model (
    input  wire logic        clk_in,
    input  wire logic [7:0]  rdata_in,
    output logic      [7:0]  addr_out,
    output logic             rd_out,
    output logic             wr_out,
    output logic      [15:0] data_out,
    output logic      [5:0]  strobe_out
);
    initial begin
        addr_out = 8'h00;
        rd_out = 1'b0;
        wr_out = 1'b0;
        data_out = 16'h0000;
        strobe_out = 6'h00;
    end
    // released data flips so a stale value never passes for a fresh one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        data_out = {8'h00, d};
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        data_out = ~data_out;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        d = rdata_in;
    endtask
    task automatic pulse(input int s, input logic [15:0] d);
        @(negedge clk_in);
        data_out = d;
        strobe_out[s] = 1'b1;
        @(negedge clk_in);
        strobe_out = 6'h00;
        data_out = ~data_out;
    endtask
endmodule
